/* logic/stm_defines.svh */
// Register offsets, reset values, counter width and timing counts of the standard timer.
`ifndef STM_DEFINES_SVH
`define STM_DEFINES_SVH
`define STM_ADDR_W         3
`define STM_OFF_CTRL_A     3'h0
`define STM_OFF_CTRL_B     3'h1
`define STM_OFF_CNT_LO     3'h2
`define STM_OFF_CNT_HI     3'h3
`define STM_OFF_CMPA_LO    3'h4
`define STM_OFF_CMPA_HI    3'h5
`define STM_OFF_CAPT_LO    3'h6
`define STM_OFF_CAPT_HI    3'h7
`define STM_CTRL_RESET     8'h00
`define STM_CNT_W          10
`define STM_CNT_MAX        10'h3FF
`define STM_SYS_DIV        4'h3
`define STM_HI_DIV16       4'hF
`define STM_HI_DIV64       6'h3F
`define STM_SUB_DIV        9'h12B
`endif

/* logic/stm_pkg.sv */
// Types shared by the standard timer design.
package stm_pkg;
    typedef enum logic [1:0] {
        STM_MODE_COMPARE = 2'h0,
        STM_MODE_CAPTURE = 2'h1,
        STM_MODE_PWM     = 2'h2,
        STM_MODE_TIMER   = 2'h3
    } stm_mode_type;

    typedef struct packed {
        logic       pause_bit;
        logic [2:0] clock_select_field;
        logic       run_enable_bit;
        logic [2:0] period_compare_field;
    } stm_ctrl_a_type;

    typedef struct packed {
        stm_mode_type mode_field;
        logic [1:0]   pin_function_field;
        logic         output_control_bit;
        logic         polarity_bit;
        logic         duty_period_select_bit;
        logic         clear_select_bit;
    } stm_ctrl_b_type;

    typedef enum {
        STM_PULSE_IDLE,
        STM_PULSE_ACTIVE
    } stm_pulse_state_type;
endpackage : stm_pkg

/* logic/stm_timer.sv */
// Standard 10-bit timer: control registers, counter, comparators and pin logic.
//
// Overview of operation
// - Pause bit holds the counter value; clearing it resumes from there.
// - Clock select field picks sys/4, sys, high/16, high/64, sub, ext edges.
// - Run enable rising edge zeroes counter; clearing it stops and keeps value.
// - Compare mode: run enable rising edge restores the initial pin level.
// - Period value is compared with counter bits 9..7; zero means 1024 clocks.
// - Period value zero lets the counter run to maximum and overflow.
// - Mode field: compare output, capture, PWM/single pulse, timer/counter.
// - Timer/counter mode drives the pin low; control and polarity unused.
// - Compare mode match A: keep, drive low, drive high or toggle pin.
// - PWM mode pin field: inactive, active, PWM or single pulse output.
// - Capture mode pin field: rising, falling, both edges, or disabled.
// - A match asking for the level already present shows no change.
// - Output control bit: initial level in compare, active level in PWM.
// - Polarity bit inverts the output pin except in timer/counter mode.
// - Duty/period select bit swaps comparator roles in PWM mode.
// - Clear select 1 clears on match A, 0 on match P or overflow.
// - Clear select bit is ignored in PWM, single pulse and capture modes.
// - Counter readable as a byte pair; comparator A value is read/write pair.
// - Low compare byte writes go to a buffer, copied on high byte write.
// - High byte reads latch the low byte into the buffer for later read.
// - Counter clear by overflow or match raises the interrupt signal.
// - With clear select high in compare or timer mode only the comparator A flag is raised.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "stm_defines.svh"

module stm_timer
    import stm_pkg::*;
(
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic [`STM_ADDR_W-1:0] addr_i,
    input  wire logic [7:0]             wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output var  logic [7:0]             rdata_o,
    input  wire logic                   high_clk_tick_i,
    input  wire logic                   external_clock_pin_i,
    input  wire logic                   capture_input_pin_i,
    output var  logic                   timer_output_pin_o,
    output var  logic                   timer_output_pin_b_o,
    output var  logic                   comparator_a_flag_o,
    output var  logic                   comparator_p_flag_o,
    output var  logic                   timer_irq_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Filtered level of a three-stage synchroniser: changes when stages two and three agree.
    function automatic logic filt(input logic [2:0] s, input logic prev);
        return (s[1] == s[2]) ? s[2] : prev;
    endfunction

    // Next value of a free-running prescaler counting down to zero.
    function automatic logic [8:0] prescale(input logic [8:0] c, input logic [8:0] top);
        return (c == 9'h000) ? top : c - 9'h001;
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    stm_ctrl_a_type              ctrl_a_q;
    stm_ctrl_b_type              ctrl_b_q;
    logic [`STM_CNT_W-1:0]       count_q;
    logic [`STM_CNT_W-1:0]       cmpa_q;
    logic [`STM_CNT_W-1:0]       capt_q;
    logic [7:0]                  buf_q;
    logic                        run_prev_q;
    logic [2:0]                  ext_sync_q;
    logic [2:0]                  cap_sync_q;
    logic [2:0]                  hi_sync_q;
    logic                        ext_lvl_q;
    logic                        cap_lvl_q;
    logic                        hi_lvl_q;
    logic [8:0]                  sys_div_q;
    logic [8:0]                  hi_div_q;
    logic [8:0]                  sub_div_q;
    logic                        pin_q;
    stm_pulse_state_type         pulse_q;
    logic                        tick;
    logic                        run_rise;
    logic                        match_a;
    logic                        match_p;
    logic                        overflow;
    logic                        clear_cnt;
    logic                        pwm_level;
    logic                        ext_rise;
    logic                        ext_fall;
    logic                        cap_rise;
    logic                        cap_fall;
    logic                        hi_tick;
    logic                        capture_ev;
    logic                        pin_raw;
    logic [`STM_CNT_W-1:0]       period_full;

    assign run_rise = ctrl_a_q.run_enable_bit & ~run_prev_q;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------

    // Three stages on each pin; only stages two and three feed the filtered level.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_sync_q <= 3'h0;
            cap_sync_q <= 3'h0;
            hi_sync_q  <= 3'h0;
            ext_lvl_q  <= 1'b0;
            cap_lvl_q  <= 1'b0;
            hi_lvl_q   <= 1'b0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], external_clock_pin_i};
            cap_sync_q <= {cap_sync_q[1:0], capture_input_pin_i};
            hi_sync_q  <= {hi_sync_q[1:0], high_clk_tick_i};
            ext_lvl_q  <= filt(ext_sync_q, ext_lvl_q);
            cap_lvl_q  <= filt(cap_sync_q, cap_lvl_q);
            hi_lvl_q   <= filt(hi_sync_q, hi_lvl_q);
        end
    end

    assign ext_rise = filt(ext_sync_q, ext_lvl_q) & ~ext_lvl_q;
    assign ext_fall = ~filt(ext_sync_q, ext_lvl_q) & ext_lvl_q;
    assign cap_rise = filt(cap_sync_q, cap_lvl_q) & ~cap_lvl_q;
    assign cap_fall = ~filt(cap_sync_q, cap_lvl_q) & cap_lvl_q;
    assign hi_tick  = filt(hi_sync_q, hi_lvl_q) & ~hi_lvl_q;

    // ----------------------------------------------------------------
    // Count clock selection
    // ----------------------------------------------------------------

    // Prescalers run always so that the selected rate is steady when the timer starts.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sys_div_q <= 9'h000;
            hi_div_q  <= 9'h000;
            sub_div_q <= 9'h000;
        end else begin
            sys_div_q <= prescale(sys_div_q, {5'h00, `STM_SYS_DIV});
            sub_div_q <= prescale(sub_div_q, `STM_SUB_DIV);
            if (hi_tick) begin
                hi_div_q <= prescale(hi_div_q, {3'h0, `STM_HI_DIV64});
            end
        end
    end

    // The sub clock is approximated from the system clock; the high clock arrives as pin ticks.
    always_comb begin
        case (ctrl_a_q.clock_select_field)
            3'h0:    tick = (sys_div_q == 9'h000);
            3'h1:    tick = 1'b1;
            3'h2:    tick = hi_tick & (hi_div_q[3:0] == 4'h0);
            3'h3:    tick = hi_tick & (hi_div_q[5:0] == 6'h00);
            3'h4:    tick = (sub_div_q == 9'h000);
            3'h5:    tick = (sub_div_q == 9'h000);
            3'h6:    tick = ext_rise;
            default: tick = ext_fall;
        endcase
    end

    // ----------------------------------------------------------------
    // Comparators
    // ----------------------------------------------------------------
    assign match_p     = (count_q == period_full - 10'h001)
                         && (ctrl_a_q.period_compare_field != 3'h0);
    assign match_a     = (count_q + 10'h001 == cmpa_q) && (cmpa_q != 10'h000);
    assign overflow    = (count_q == `STM_CNT_MAX);
    assign period_full = {ctrl_a_q.period_compare_field, 7'h00};

    // Clear source: PWM uses the period comparator chosen by the duty/period bit.
    always_comb begin
        if (ctrl_b_q.mode_field == STM_MODE_PWM) begin
            clear_cnt = ctrl_b_q.duty_period_select_bit ? match_a
                                                        : (match_p | overflow);
        end else if (ctrl_b_q.mode_field == STM_MODE_CAPTURE) begin
            clear_cnt = overflow;
        end else if (ctrl_b_q.clear_select_bit) begin
            clear_cnt = match_a;
        end else begin
            clear_cnt = match_p | overflow;
        end
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------

    // The counter moves only on a count tick while running and not paused, or to zero on a run enable rise.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_q    <= 10'h000;
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= ctrl_a_q.run_enable_bit;
            if (run_rise) begin
                count_q <= 10'h000;
            end else if (ctrl_a_q.run_enable_bit && !ctrl_a_q.pause_bit && tick) begin
                count_q <= clear_cnt ? 10'h000 : count_q + 10'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Flags and interrupt
    // ----------------------------------------------------------------

    // Flags are one-cycle event pulses taken at the counting edge of a match.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            comparator_a_flag_o <= 1'b0;
            comparator_p_flag_o <= 1'b0;
            timer_irq_o         <= 1'b0;
        end else begin
            comparator_a_flag_o <= tick && ctrl_a_q.run_enable_bit && !ctrl_a_q.pause_bit
                                   && match_a && ctrl_b_q.mode_field != STM_MODE_CAPTURE;
            comparator_p_flag_o <= tick && ctrl_a_q.run_enable_bit && !ctrl_a_q.pause_bit
                                   && (match_p | overflow)
                                   && !(ctrl_b_q.clear_select_bit
                                        && ctrl_b_q.mode_field[1] == ctrl_b_q.mode_field[0]);
            timer_irq_o         <= (tick && ctrl_a_q.run_enable_bit && !ctrl_a_q.pause_bit
                                    && (clear_cnt | match_a)) | capture_ev;
        end
    end

    // ----------------------------------------------------------------
    // Capture
    // ----------------------------------------------------------------
    always_comb begin
        case (ctrl_b_q.pin_function_field)
            2'h0:    capture_ev = cap_rise;
            2'h1:    capture_ev = cap_fall;
            2'h2:    capture_ev = cap_rise | cap_fall;
            default: capture_ev = 1'b0;
        endcase
        if (ctrl_b_q.mode_field != STM_MODE_CAPTURE || !ctrl_a_q.run_enable_bit) begin
            capture_ev = 1'b0;
        end
    end

    // Captured count is held so software can read the edge time.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            capt_q <= 10'h000;
        end else if (capture_ev) begin
            capt_q <= count_q;
        end
    end

    // ----------------------------------------------------------------
    // Output pin
    // ----------------------------------------------------------------

    // PWM duty level; a duty at or above the period gives full duty.
    always_comb begin
        if (ctrl_b_q.duty_period_select_bit) begin
            pwm_level = (ctrl_a_q.period_compare_field == 3'h0) ? 1'b1
                        : (count_q < period_full);
        end else begin
            pwm_level = (count_q < cmpa_q);
        end
    end

    // Pin state machine: compare actions, PWM forcing and single pulse.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_q   <= 1'b0;
            pulse_q <= STM_PULSE_IDLE;
        end else begin
            case (ctrl_b_q.mode_field)
                STM_MODE_COMPARE: begin
                    if (run_rise) begin
                        pin_q <= ctrl_b_q.output_control_bit;
                    end else if (tick && ctrl_a_q.run_enable_bit && !ctrl_a_q.pause_bit
                                 && match_a) begin
                        // Driving an already present level leaves the pin unchanged.
                        case (ctrl_b_q.pin_function_field)
                            2'h1:    pin_q <= 1'b0;
                            2'h2:    pin_q <= 1'b1;
                            2'h3:    pin_q <= ~pin_q;
                            default: pin_q <= pin_q;
                        endcase
                    end
                end
                STM_MODE_PWM: begin
                    case (ctrl_b_q.pin_function_field)
                        2'h0:    pin_q <= 1'b0;
                        2'h1:    pin_q <= 1'b1;
                        2'h2:    pin_q <= ctrl_a_q.run_enable_bit & pwm_level;
                        default: begin
                            // Single pulse: trigger by run rise or external rising edge.
                            case (pulse_q)
                                STM_PULSE_IDLE: begin
                                    pin_q <= 1'b0;
                                    if (run_rise || (ctrl_a_q.run_enable_bit && ext_rise)) begin
                                        pulse_q <= STM_PULSE_ACTIVE;
                                        pin_q   <= 1'b1;
                                    end
                                end
                                STM_PULSE_ACTIVE: begin
                                    if (!ctrl_a_q.run_enable_bit || (tick && match_a)) begin
                                        pulse_q <= STM_PULSE_IDLE;
                                        pin_q   <= 1'b0;
                                    end
                                end
                                default: pulse_q <= STM_PULSE_IDLE;
                            endcase
                        end
                    endcase
                end
                default: pin_q <= pin_q;
            endcase
        end
    end

    // Active level and polarity; timer/counter mode leaves the pin low and unused.
    always_comb begin
        if (ctrl_b_q.mode_field == STM_MODE_PWM) begin
            pin_raw = ctrl_b_q.output_control_bit ? pin_q : ~pin_q;
        end else begin
            pin_raw = pin_q;
        end
        pin_raw = pin_raw ^ ctrl_b_q.polarity_bit;
        if (ctrl_b_q.mode_field == STM_MODE_TIMER) begin
            pin_raw = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            timer_output_pin_o   <= 1'b0;
            timer_output_pin_b_o <= 1'b1;
        end else begin
            timer_output_pin_o   <= pin_raw;
            timer_output_pin_b_o <= ~pin_raw;
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------

    // Control registers; the mode and pin fields are expected to change only while off.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_a_q <= `STM_CTRL_RESET;
            ctrl_b_q <= `STM_CTRL_RESET;
        end else if (wr_i && addr_i == `STM_OFF_CTRL_A) begin
            ctrl_a_q <= wdata_i;
        end else if (wr_i && addr_i == `STM_OFF_CTRL_B) begin
            ctrl_b_q <= wdata_i;
        end
    end

    // Shared byte buffer and the comparator A pair.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            buf_q  <= 8'h00;
            cmpa_q <= 10'h000;
        end else if (wr_i && addr_i == `STM_OFF_CMPA_LO) begin
            buf_q <= wdata_i;
        end else if (wr_i && addr_i == `STM_OFF_CMPA_HI) begin
            cmpa_q <= {wdata_i[1:0], buf_q};
        end else if (rd_i && addr_i == `STM_OFF_CNT_HI) begin
            buf_q <= count_q[7:0];
        end else if (rd_i && addr_i == `STM_OFF_CMPA_HI) begin
            buf_q <= cmpa_q[7:0];
        end else if (rd_i && addr_i == `STM_OFF_CAPT_HI) begin
            buf_q <= capt_q[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------

    // Read data stand for exactly one cycle after the strobe; otherwise zero.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
        end else if (!rd_i) begin
            rdata_o <= 8'h00;
        end else begin
            case (addr_i)
                `STM_OFF_CTRL_A:  rdata_o <= ctrl_a_q;
                `STM_OFF_CTRL_B:  rdata_o <= ctrl_b_q;
                `STM_OFF_CNT_LO:  rdata_o <= buf_q;
                `STM_OFF_CNT_HI:  rdata_o <= {6'h00, count_q[9:8]};
                `STM_OFF_CMPA_LO: rdata_o <= buf_q;
                `STM_OFF_CMPA_HI: rdata_o <= {6'h00, cmpa_q[9:8]};
                `STM_OFF_CAPT_LO: rdata_o <= buf_q;
                default:          rdata_o <= {6'h00, capt_q[9:8]};
            endcase
        end
    end

endmodule // stm_timer
`default_nettype wire

/* bench/stm_timer_assertions.sv */
// Port-level checker for the standard timer, bound to the design.
`timescale 1ns/100ps
`default_nettype none
`include "stm_defines.svh"
module stm_timer_checker (
    input wire logic       sys_clk_i,
    input wire logic       rst_b_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       timer_output_pin_o,
    input wire logic       timer_output_pin_b_o,
    input wire logic       comparator_a_flag_o,
    input wire logic       comparator_p_flag_o
);
    // ----------------------------------------
    // Shadow of control register B
    // ----------------------------------------
    logic [7:0] ctrl_b_q;
    logic [2:0] quiet_q;

    // The quiet count lets flags already in flight drain after a write.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_b_q <= 8'h00;
            quiet_q  <= 3'h0;
        end else if (wr_i && addr_i == `STM_OFF_CTRL_B) begin
            ctrl_b_q <= wdata_i;
            quiet_q  <= 3'h0;
        end else if (quiet_q != 3'h7) begin
            quiet_q <= quiet_q + 3'h1;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence ctrl_wr_s;
        wr_i && addr_i == `STM_OFF_CTRL_B;
    endsequence
    sequence ctrl_rd_s;
        rd_i && addr_i == `STM_OFF_CTRL_B;
    endsequence

    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    pin_inverse_a: assert property (timer_output_pin_b_o == !timer_output_pin_o)
        else $error("inverted pin does not mirror the pin");
    hi_pad_a: assert property ($past(rd_i) && $past(addr_i) inside {3'h3, 3'h5}
        |-> rdata_o[7:2] == 6'h00) else $error("unused high bits not zero");
    ctrl_readback_a: assert property (ctrl_wr_s ##1 !wr_i ##1 ctrl_rd_s
        |=> rdata_o == $past(wdata_i, 3)) else $error("control B readback wrong");
    aflag_pulse_a: assert property (comparator_a_flag_o |=> !comparator_a_flag_o)
        else $error("flag A longer than one cycle");
    pflag_pulse_a: assert property (comparator_p_flag_o |=> !comparator_p_flag_o)
        else $error("flag P longer than one cycle");
    p_suppress_a: assert property (quiet_q == 3'h7 && ctrl_b_q[0]
        && ctrl_b_q[7] == ctrl_b_q[6] |-> !comparator_p_flag_o) else $error("flag P raised");
    capt_noflag_a: assert property (quiet_q == 3'h7 && ctrl_b_q[7:6] == 2'h1
        |-> !comparator_a_flag_o) else $error("flag A raised in capture mode");
endmodule // stm_timer_checker

bind stm_timer stm_timer_checker u_stm_chk (.sys_clk_i, .rst_b_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .timer_output_pin_o, .timer_output_pin_b_o,
    .comparator_a_flag_o, .comparator_p_flag_o);
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking testbench of the standard timer.
`timescale 1ns/100ps
`default_nettype none
`include "stm_defines.svh"
module tb_top;
    logic       sys_clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic       high_clk_tick_i = 1'b0, external_clock_pin_i = 1'b0;
    logic       capture_input_pin_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, d;
    logic       timer_output_pin_o, timer_output_pin_b_o, timer_irq_o;
    logic       comparator_a_flag_o, comparator_p_flag_o, lvl;
    logic [9:0] v, w;
    int         err_count = 0, n_checks = 0, cyc = 0, n;
    int         tbl [6][3] = '{'{1,1,128}, '{1,0,1024}, '{0,1,512}, '{2,1,8192},
                               '{6,1,512}, '{7,1,512}};
    int         pwm_exp [4] = '{0, 128, 32, 96};

    stm_timer dut (.sys_clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .high_clk_tick_i, .external_clock_pin_i, .capture_input_pin_i, .timer_output_pin_o,
        .timer_output_pin_b_o, .comparator_a_flag_o, .comparator_p_flag_o, .timer_irq_o);

    always #50 sys_clk_i = ~sys_clk_i;

    // Count pins toggle every second cycle so the pin filter passes them; cyc stops a hang.
    always @(posedge sys_clk_i) begin
        high_clk_tick_i <= cyc[1];
        external_clock_pin_i <= cyc[1];
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            results();
        end
    end

    // ----------------------------------------
    // Access and check tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] x);
        addr_i <= a;
        wdata_i <= x;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken at that edge.
    task automatic rd(input logic [2:0] a, output logic [7:0] x);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        @(posedge sys_clk_i);
        x = rdata_o;
    endtask
    task automatic rd_cnt(output logic [9:0] x);
        logic [7:0] h, l;
        rd(`STM_OFF_CNT_HI, h);
        rd(`STM_OFF_CNT_LO, l);
        x = {h[1:0], l};
    endtask
    // Mode and pin settings only change while the timer is off.
    task automatic restart(input logic [7:0] a, input logic [7:0] b);
        wr(`STM_OFF_CTRL_A, a & 8'hF7);
        wr(`STM_OFF_CTRL_B, b);
        wr(`STM_OFF_CTRL_A, a);
    endtask
    task automatic wait_flag(input logic p, output int k);
        k = 1;
        @(posedge sys_clk_i);
        while ((p ? comparator_p_flag_o : comparator_a_flag_o) !== 1'b1 && k < 20000) begin
            @(posedge sys_clk_i);
            k++;
        end
        chk(timer_irq_o, 1'b1);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        @(posedge sys_clk_i);
        rd(`STM_OFF_CTRL_A, d);
        chk(d, 8'h00);
        wr(`STM_OFF_CNT_LO, 8'hFF);
        rd_cnt(v);
        chk(v, 10'h000);
        wr(`STM_OFF_CTRL_B, 8'h5A);
        rd(`STM_OFF_CTRL_B, d);
        chk(d, 8'h5A);
        wr(`STM_OFF_CMPA_LO, 8'hA5);
        rd(`STM_OFF_CMPA_HI, d);
        rd(`STM_OFF_CMPA_LO, d);
        chk(d, 8'h00);
        wr(`STM_OFF_CMPA_LO, 8'hA5);
        wr(`STM_OFF_CMPA_HI, 8'hFE);
        rd(`STM_OFF_CMPA_HI, d);
        chk(d, 8'h02);
        rd(`STM_OFF_CMPA_LO, d);
        chk(d, 8'hA5);
        $display("test registers done");
        wr(`STM_OFF_CTRL_A, 8'h18);
        repeat (20) @(posedge sys_clk_i);
        wr(`STM_OFF_CTRL_A, 8'h98);
        rd_cnt(v);
        repeat (40) @(posedge sys_clk_i);
        rd_cnt(w);
        chk(w, v);
        wr(`STM_OFF_CTRL_A, 8'h18);
        rd_cnt(w);
        chk(w > v && w < v + 10'd16, 1'b1);
        wr(`STM_OFF_CTRL_A, 8'h10);
        rd_cnt(v);
        repeat (40) @(posedge sys_clk_i);
        rd_cnt(w);
        chk(w, v);
        wr(`STM_OFF_CTRL_A, 8'h18);
        rd_cnt(w);
        chk(w < 10'd16, 1'b1);
        $display("test pause done");
        wr(`STM_OFF_CMPA_LO, 8'h40);
        wr(`STM_OFF_CMPA_HI, 8'h00);
        for (int i = 0; i < 16; i++) begin
            restart(8'h18, {2'b00, 2'(i), i[2], i[3], 2'b01});
            repeat (4) @(posedge sys_clk_i);
            chk(timer_output_pin_o, i[2] ^ i[3]);
            wait_flag(1'b0, n);
            repeat (3) @(posedge sys_clk_i);
            lvl = (i[1:0] == 2'h0) ? i[2] : (i[1:0] == 2'h3) ? !i[2] : i[1];
            chk(timer_output_pin_o, lvl ^ i[3]);
            wait_flag(1'b0, n);
            wait_flag(1'b0, n);
            chk(16'(n), 16'd64);
        end
        $display("test compare done");
        for (int i = 0; i < 6; i++) begin
            restart({1'b0, 3'(tbl[i][0]), 1'b1, 3'(tbl[i][1])}, {i[0], i[0], 6'h00});
            wait_flag(1'b1, n);
            wait_flag(1'b1, n);
            chk(16'(n), 16'(tbl[i][2]));
        end
        $display("test period done");
        wr(`STM_OFF_CMPA_LO, 8'h20);
        wr(`STM_OFF_CMPA_HI, 8'h00);
        for (int i = 0; i < 4; i++) begin
            restart(8'h19, {2'b10, (i == 3) ? 2'h2 : 2'(i), 1'b1, i == 3, 2'b00});
            repeat (300) @(posedge sys_clk_i);
            n = 0;
            repeat (128) begin
                @(posedge sys_clk_i);
                n += timer_output_pin_o;
            end
            chk(16'(n), 16'(pwm_exp[i]));
        end
        $display("test pwm done");
        restart(8'h18, 8'h40);
        capture_input_pin_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        rd(`STM_OFF_CAPT_HI, d);
        rd(`STM_OFF_CAPT_LO, d);
        chk(d, 8'h03);
        $display("test capture done");
        results();
    end
endmodule // tb_top
`default_nettype wire
